// [verilog/lcps_pkg.sv]
// Purpose: Constants for the LCD pin duty select block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Offsets are local choices; no offsets are printed for these registers.
package lcps_pkg;
  localparam logic [11:0] LCPS_OFF_CTRL = 12'h000;
  localparam logic [11:0] LCPS_OFF_MID = 12'h004;
  localparam logic [11:0] LCPS_OFF_HIGH = 12'h008;
  localparam logic [11:0] LCPS_OFF_PINS = 12'h00c;
  localparam int LCPS_ENABLE_BIT = 0;
  localparam int LCPS_HIGH_FULL_BITS = 6;
  localparam int LCPS_HIGH_REDUCED_BITS = 2;
  localparam logic [7:0] LCPS_RESET_SEL = 8'h00;
  localparam logic LCPS_RESET_EN = 1'b0;
  localparam logic [31:0] LCPS_ZERO_WORD = 32'h00000000;
endpackage : lcps_pkg

// [verilog/lcps_sel_reg.sv]
// Purpose: Holds one group of pin duty selection bits.
// Assumes: Write strobe comes from logic on pclk.
// Notes: Unimplemented bits are absent, so they read as zero.
`timescale 1ns/1ns
module lcps_sel_reg #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] sel_out
);
  logic [WIDTH-1:0] sel_reg;

  // A group wider than one byte would not fit the byte-wide write path.
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("lcps_sel_reg width must be 1 to 8.");
  end

  // Bits clear at reset so every pin begins in common duty.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= lcps_pkg::LCPS_RESET_SEL[WIDTH-1:0];
    end else if (clk_en && wr_en) begin
      sel_reg <= wr_data[WIDTH-1:0];
    end
  end

  // Upper bits beyond WIDTH are tied to zero for readback.
  assign sel_out = 8'(sel_reg);
endmodule : lcps_sel_reg

// [verilog/lcps_top.sv]
// Purpose: APB register block choosing common or segment duty for LCD pins 8 to 21.
// Assumes: Single 10 MHz clock; the output stage decodes duty and drive per pin.
// Notes: FULL_SIZE selects the 14-pin variant (pins 8 to 21); zero selects the reduced one.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ns
module lcps_top #(
  parameter bit FULL_SIZE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic lcd_output_enable,
  output logic [13:0] lcd_segment_line_pin,
  output logic [13:0] lcd_pin_active
);
  // Register map, one aligned word per register, low byte used except in the pin view:
  //   control word: bit 0 is the LCD output enable, reset off.
  //   mid select word: bits 7..0 pick the duty of pins 15..8.
  //   high select word: bits 5..0 pick the duty of pins 21..16 in the full
  //   variant; only bits 1..0 exist in the reduced one.
  //   pin view word: read-only copy of the registered pin outputs, the
  //   segment vector in bits 13..0 and the active vector in bits 29..16.
  // A select bit of zero puts its pin in common duty, a one in segment duty.
  // Unbuilt select bits are not stored at all, so they cannot read back as
  // anything but zero and cost no flops in the reduced variant.
  // The pin outputs are registered once more after the select bits, so a
  // write shows on the pins one edge after it lands in the register.
  // The slave answers with no wait states; a read word is taken from the
  // register file at the setup edge and held until the next read setup.
  // An unmapped address, or a write to the pin view, answers with an error;
  // the write is dropped and a read returns zero.
  // While the clock enable is low nothing moves, bus writes included, so
  // software must not access the block during a frozen period.
  localparam int HIGH_BITS = FULL_SIZE ? lcps_pkg::LCPS_HIGH_FULL_BITS
                                       : lcps_pkg::LCPS_HIGH_REDUCED_BITS;

  // The duty vector has room for six high bits; group widths outside 2 to 6 are refused.
  if (HIGH_BITS < lcps_pkg::LCPS_HIGH_REDUCED_BITS ||
      HIGH_BITS > lcps_pkg::LCPS_HIGH_FULL_BITS) begin : g_bad_width
    $error("lcps_top high group width out of range.");
  end

  logic [7:0] mid_sel;
  logic [7:0] high_sel;
  logic en_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pready_reg;
  logic [13:0] seg_reg;
  logic [13:0] act_reg;

  // Decode of the APB access phase.
  wire acc = psel && penable;
  wire hit_ctrl = paddr == lcps_pkg::LCPS_OFF_CTRL;
  wire hit_mid = paddr == lcps_pkg::LCPS_OFF_MID;
  wire hit_high = paddr == lcps_pkg::LCPS_OFF_HIGH;
  wire hit_pins = paddr == lcps_pkg::LCPS_OFF_PINS;
  wire mapped = hit_ctrl || hit_mid || hit_high || hit_pins;
  wire wr_mid = acc && pwrite && hit_mid;
  wire wr_high = acc && pwrite && hit_high;
  wire wr_ctrl = acc && pwrite && hit_ctrl;
  // The pin view register is read-only, so a write to it is an error.
  wire bad = !mapped || (pwrite && hit_pins);

  // Full duty vector for pins 21..8; unbuilt pins stay in common duty.
  wire [13:0] duty = {high_sel[5:0], mid_sel};
  // Pins are all low while the LCD is off, whatever their duty.
  wire [13:0] act_next = en_reg ? {14{1'b1}} : 14'h0000;
  wire [13:0] seg_next = duty & act_next;

  wire [31:0] rd_next = hit_ctrl ? 32'(en_reg)
                      : hit_mid ? 32'(mid_sel)
                      : hit_high ? 32'(high_sel)
                      : hit_pins ? 32'({act_reg, 2'h0, seg_reg})
                      : lcps_pkg::LCPS_ZERO_WORD;

  lcps_sel_reg #(.WIDTH(8)) u_mid (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .wr_en(wr_mid),
    .wr_data(pwdata[7:0]),
    .sel_out(mid_sel)
  );

  lcps_sel_reg #(.WIDTH(HIGH_BITS)) u_high (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .wr_en(wr_high),
    .wr_data(pwdata[7:0]),
    .sel_out(high_sel)
  );

  // Enable bit starts off so the panel sees no drive before software sets it up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= lcps_pkg::LCPS_RESET_EN;
    end else if (clk_en && wr_ctrl) begin
      en_reg <= pwdata[lcps_pkg::LCPS_ENABLE_BIT];
    end
  end

  // Ready comes from a flop so the bus sees a clean level; it rises after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else if (clk_en) begin
      pready_reg <= 1'b1;
    end
  end

  // Read data and error are registered at the setup edge and stand for the
  // access phase; the error flag drops again at the edge that ends it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= lcps_pkg::LCPS_ZERO_WORD;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      prdata_reg <= (psel && !penable && !pwrite) ? rd_next : prdata_reg;
      pslverr_reg <= psel && !penable && bad;
    end
  end

  // Pin drive registers lag the selection by one edge, giving outputs from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_reg <= 14'h0000;
      act_reg <= 14'h0000;
    end else if (clk_en) begin
      seg_reg <= seg_next;
      act_reg <= act_next;
    end
  end

  // Every output is a plain copy of a flop.
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready = pready_reg;
  assign lcd_output_enable = en_reg;
  assign lcd_segment_line_pin = seg_reg;
  assign lcd_pin_active = act_reg;

  a_high_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    high_sel[7:6] == 2'h0) else $error("High select upper bits not zero.");
  a_reduced_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !FULL_SIZE |-> high_sel[7:2] == 6'h00) else $error("Reduced bits not zero.");
  a_off_grounds: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !en_reg |=> lcd_segment_line_pin == 14'h0000 && lcd_pin_active == 14'h0000)
    else $error("Pins driven while disabled.");
  a_mid_write: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_mid |=> mid_sel == $past(pwdata[7:0])) else $error("Mid write lost.");
  a_mid_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(clk_en && wr_mid) |=> $stable(mid_sel)) else $error("Mid changed unwritten.");
  a_seg_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && en_reg |=> lcd_segment_line_pin[7:0] == $past(mid_sel))
    else $error("Segment pins not following select.");
  a_high_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && en_reg && FULL_SIZE |=> lcd_segment_line_pin[13:8] == $past(high_sel[5:0]))
    else $error("High pins not following select.");
  a_rst_zero: assert property (@(posedge pclk)
    $rose(presetn) |-> mid_sel == 8'h00 && high_sel == 8'h00)
    else $error("Selects not clear after reset.");

  c_enable_on: cover property (@(posedge pclk) disable iff (!presetn) $rose(en_reg));
  c_mid_wr: cover property (@(posedge pclk) disable iff (!presetn) wr_mid);
  c_high_wr: cover property (@(posedge pclk) disable iff (!presetn) wr_high);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

  // Bus side checks: ready, error and read data line up with the setup edge.
  a_ready_up: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(presetn) |=> pready) else $error("Ready not high.");
  a_err_match: assert property (@(posedge pclk) disable iff (!presetn)
    $past(clk_en && psel && !penable) && acc |-> pslverr == bad)
    else $error("Error flag wrong in access.");
  a_rd_mid: assert property (@(posedge pclk) disable iff (!presetn)
    $past(clk_en && psel && !penable && !pwrite) && acc && hit_mid |-> prdata == 32'(mid_sel))
    else $error("Mid readback wrong.");
  a_rd_high: assert property (@(posedge pclk) disable iff (!presetn)
    $past(clk_en && psel && !penable && !pwrite) && acc && hit_high |-> prdata[31:6] == 26'h0)
    else $error("High readback upper bits set.");
  a_rd_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    $past(clk_en && psel && !penable && !pwrite) && acc && !mapped |-> prdata == 32'h0)
    else $error("Unmapped read not zero.");

  // Enable and freeze checks on the pin side.
  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_ctrl |=> lcd_output_enable == $past(pwdata[lcps_pkg::LCPS_ENABLE_BIT]))
    else $error("Enable write lost.");
  a_act_on: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && en_reg |=> lcd_pin_active == {14{1'b1}})
    else $error("Pins inactive while enabled.");
  a_freeze_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(mid_sel) && $stable(lcd_segment_line_pin) && $stable(lcd_output_enable))
    else $error("State moved while frozen.");

  c_pins_read: cover property (@(posedge pclk) disable iff (!presetn) acc && hit_pins && !pwrite);
endmodule : lcps_top

// [bench/lcps_pin_model.sv]
// Purpose: Behavioural LCD output stage that drives the shared pins.
// Assumes: Inputs come straight from the duty select block.
// Notes: A pin is grounded unless the block enables it.
`timescale 1ns/1ns
module lcps_pin_model (
  input wire logic en,
  input wire logic [13:0] seg,
  input wire logic [13:0] act,
  output logic [13:0] seg_drive,
  output logic [13:0] com_drive
);
  // Gating on the enable keeps the panel dark while it is switched off.
  assign seg_drive = en ? seg : 14'h0000;
  assign com_drive = en ? (act & ~seg) : 14'h0000;
endmodule : lcps_pin_model

// [bench/tb_lcps_top.sv]
// Purpose: Self-checking bench for the LCD pin duty select block.
// Assumes: Zero-wait slave; clk_en held high except for one write made while it is low.
// Notes: Reads are checked by a monitor against a queue of expected words.
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb_lcps_top;
  logic pclk = 0, presetn, clk_en, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic pready, pslverr, lcd_output_enable;
  logic [31:0] prdata_red;
  logic [13:0] seg, act, seg_drive, com_drive;
  logic [32:0] exp_q[$];
  logic [32:0] n;
  int failures = 0, compares = 0, i;
  lcps_top #(.FULL_SIZE(1'b1)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lcd_output_enable(lcd_output_enable), .lcd_segment_line_pin(seg), .lcd_pin_active(act));
  // Reduced variant shares the bus; only its read data is watched.
  lcps_top #(.FULL_SIZE(1'b0)) dut_red (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_red), .pready(), .pslverr(),
    .lcd_output_enable(), .lcd_segment_line_pin(), .lcd_pin_active());
  lcps_pin_model pins (.en(lcd_output_enable), .seg(seg), .act(act),
    .seg_drive(seg_drive), .com_drive(com_drive));
  // Clock at 10 MHz.
  always #50 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic complete_run();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // One APB transfer; the expected {error, data} is queued for the monitor.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Monitor takes the oldest note at every completed access, mid-cycle so
  // the registered answer has settled.
  always @(negedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      n = exp_q.pop_front();
      `CHK("pslverr", n[32], pslverr)
      if (!pwrite) `CHK("prdata", n[31:0], prdata)
    end
  end
  // Watchdog far beyond the expected run of under two hundred cycles.
  initial begin
    #2000000;
    failures++;
    complete_run();
  end
  initial begin
    presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    seed = 32'h04f54ef8;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) apb(1'b0, 12'(i * 4), 32'h0, 33'h0);
    // Random selections, enable toggled each pass so both pin states are seen.
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      r = seed;
      apb(1'b1, 12'h004, r, 33'h0);
      apb(1'b1, 12'h008, r >> 8, 33'h0);
      apb(1'b1, 12'h000, {31'h0, i[0]}, 33'h0);
      apb(1'b0, 12'h004, 32'h0, {1'b0, 24'h0, r[7:0]});
      apb(1'b0, 12'h008, 32'h0, {1'b0, 26'h0, r[13:8]});
      apb(1'b0, 12'h00c, 32'h0, i[0] ? {3'h0, 14'h3fff, 2'h0, r[13:0]} : 33'h0);
    end
    // A write while the clock enable is low must be lost.
    clk_en <= 1'b0;
    apb(1'b1, 12'h004, ~r, 33'h0);
    clk_en <= 1'b1;
    apb(1'b0, 12'h004, 32'h0, {1'b0, 24'h0, r[7:0]});
    apb(1'b0, 12'h008, 32'h0, {1'b0, 26'h0, r[13:8]});
    @(negedge pclk);
    `CHK("prdata_red", {30'h0, r[9:8]}, prdata_red)
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h00c, 32'hffffffff, {1'b1, 32'h0});
    @(negedge pclk);
    `CHK("com_drive", ~r[13:0], com_drive)
    `CHK("lcd_output_enable", 1'b1, lcd_output_enable)
    complete_run();
  end
endmodule : tb_lcps_top
